/* File: bin_to_bcd.sv */
// combinational binary to packed bcd converter
`timescale 1ns/1ps
`default_nettype none
module bin_to_bcd #(
   parameter int WIDTH = 16,
   parameter int DIGITS = 4
) (
   input wire logic [WIDTH-1:0] bin_in,     // binary value
   output logic [DIGITS*4-1:0] bcd_out      // packed decimal digits
);
   // shift-add-three; values above the digit range lose the top digits
   always_comb begin
      logic [DIGITS*4+WIDTH-1:0] work;
      work = '0;
      work[WIDTH-1:0] = bin_in;
      for (int i = 0; i < WIDTH; i++) begin
         for (int d = 0; d < DIGITS; d++) begin
            if (work[WIDTH+d*4 +: 4] > 4'h4) begin
               work[WIDTH+d*4 +: 4] = work[WIDTH+d*4 +: 4] + 4'h3;
            end
         end
         work = {work[DIGITS*4+WIDTH-2:0], 1'b0};
      end
      bcd_out = work[DIGITS*4+WIDTH-1:WIDTH];
   end
endmodule // bin_to_bcd
`default_nettype wire

/* File: drive_fault_pkg.sv */
// constants for the drive fault and monitor register bank
package drive_fault_pkg;

   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 16;

   // register offsets on the plain register port
   localparam logic [7:0] ADDR_FW_REVISION = 8'h00;
   localparam logic [7:0] ADDR_ACTIVE_FAULT = 8'h02;
   localparam logic [7:0] ADDR_STATUS_SELECT = 8'h04;
   localparam logic [7:0] ADDR_LOCKED_PARAM = 8'h06;
   localparam logic [7:0] ADDR_RESTART_PARAM = 8'h08;
   localparam logic [7:0] ADDR_RESTART_ACTIVE = 8'h0a;
   localparam logic [7:0] ADDR_VOLATILE_PARAM = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0e;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // reset values and limits
   localparam logic [15:0] FAULT_NONE = 16'h0000;
   localparam logic [15:0] FAULT_CLEAR_VALUE = 16'h0000;
   localparam logic [15:0] STATUS_SELECT_RESET = 16'h0000;
   localparam logic [15:0] STATUS_SELECT_MAX = 16'h0012;
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   localparam logic [15:0] READ_IDLE = 16'h0000;

   // interrupt status and mask layout
   localparam int IRQ_WIDTH = 3;
   localparam int IRQ_FAULT_RAISED = 0;
   localparam int IRQ_WRITE_REFUSED = 1;
   localparam int IRQ_FAULT_CLEARED = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // fault codes, held as plain binary, lowest index wins
   localparam int FAULT_COUNT = 23;
   localparam int FAULT_UNDERVOLT_INDEX = 2;
   localparam logic [15:0] FAULT_CODES [FAULT_COUNT] = '{
      16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
      16'h0008, 16'h0009, 16'h000b, 16'h000d, 16'h000e, 16'h000f, 16'h0011,
      16'h0012, 16'h0013, 16'h0014, 16'h0017, 16'h0018, 16'h0019, 16'h001a,
      16'h0030, 16'h0043};
   localparam logic [15:0] FAULT_UNDERVOLT_CODE = 16'h0003;
   localparam logic [15:0] FAULT_FW_UPGRADE_CODE = 16'h0063;

   localparam int BCD_DIGITS = 4;
   localparam int SYNC_MISC_WIDTH = 2;

endpackage

/* File: drive_fault_status_regs.sv */
// monitor and diagnosis register bank with fault latch and parameter classes
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: latched fault's code shown in fault register
// R2: code kept binary, panel gets bcd form
// R3: only zero written clears, like clear input
// R4: undervoltage only while enabled, stays latched
// R5: motion faults codes 001 to 009
// R6: codes 013, 014, 015 for stop, limits
// R7: encoder codes 011, 024, 025, 026
// R8: codes 017, 018, 048 memory, encoder output
// R9: codes 019, 020 for serial link faults
// R10: warnings use codes 023 and 067
// R11: firmware upgrade shows code 099
// R12: read-only revision word at address zero
// R13: status selector takes 0 to 18, resets 0
// R14: locked parameter refuses writes while enabled
// R15: restart parameter applies after power cycle
// R16: volatile parameter cleared by power removal
// R17: fault register reads zero without fault
// R18: writes to read-only registers are ignored
module drive_fault_status_regs
   import drive_fault_pkg::*;
#(
   parameter logic [15:0] firmware_revision_word = 16'h0064 // arbitrary value
) (
   input wire logic clk,                                   // 250 MHz clock
   input wire logic reset_n,                               // async reset, active low
   input wire logic [drive_fault_pkg::ADDR_WIDTH-1:0] reg_addr,  // register address
   input wire logic [drive_fault_pkg::DATA_WIDTH-1:0] reg_wdata, // write data
   input wire logic reg_write,                             // write strobe
   input wire logic reg_read,                              // read strobe
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] reg_rdata,     // read data, next cycle
   input wire logic drive_enabled,                         // drive enabled, same clock
   input wire logic power_cycle,                           // power off/on event pulse
   input wire logic [drive_fault_pkg::FAULT_COUNT-1:0] fault_cond_pins, // fault pins
   input wire logic fault_clear_input,                     // fault clear pin, high active
   input wire logic fw_upgrade_pin,                        // firmware upgrade in progress
   output logic irq,                                       // level interrupt
   output logic fault_active,                              // a fault is latched
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] active_fault_code, // binary code
   output logic [drive_fault_pkg::BCD_DIGITS*4-1:0] fault_bcd,      // panel bcd code
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] status_item_select, // panel item
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] locked_value,  // locked parameter
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] restart_value, // applied restart param
   output logic [drive_fault_pkg::DATA_WIDTH-1:0] volatile_value // volatile parameter
);
   import drive_fault_pkg::*;

   typedef struct packed {
      logic [15:0] fault_code;
      logic fault_active;
      logic [15:0] status_sel;
      logic [15:0] locked;
      logic [15:0] restart_staged;
      logic [15:0] restart_active;
      logic [15:0] volatile_val;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic irq;
      logic [15:0] rd_data;
      logic [BCD_DIGITS*4-1:0] fault_bcd;
   } state_type;

   localparam state_type STATE_RESET = '{
      fault_code: FAULT_NONE,
      fault_active: 1'b0,
      status_sel: STATUS_SELECT_RESET,
      locked: PARAM_RESET,
      restart_staged: PARAM_RESET,
      restart_active: PARAM_RESET,
      volatile_val: PARAM_RESET,
      irq_status: IRQ_RESET,
      irq_mask: IRQ_RESET,
      irq: 1'b0,
      rd_data: READ_IDLE,
      fault_bcd: '0};

   state_type st_reg;
   state_type st_next;

   logic [FAULT_COUNT-1:0] fault_sync;
   logic [SYNC_MISC_WIDTH-1:0] misc_sync;
   logic clear_pin_sync;
   logic fw_upgrade_sync;
   logic [BCD_DIGITS*4-1:0] bcd_of_code;

   pin_sync #(.WIDTH(FAULT_COUNT)) fault_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_in(fault_cond_pins),
      .sync_out(fault_sync)
   );

   pin_sync #(.WIDTH(SYNC_MISC_WIDTH)) misc_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_in({fw_upgrade_pin, fault_clear_input}),
      .sync_out(misc_sync)
   );

   assign clear_pin_sync = misc_sync[0];
   assign fw_upgrade_sync = misc_sync[1];

   // panel digits follow the stored code one cycle later
   bin_to_bcd #(.WIDTH(DATA_WIDTH), .DIGITS(BCD_DIGITS)) code_to_panel (
      .bin_in(st_reg.fault_code),
      .bcd_out(bcd_of_code)
   );

   always_comb begin
      logic [FAULT_COUNT-1:0] cond;
      logic [15:0] new_code;
      logic wr_fault;
      logic clear_req;
      logic refused;
      logic [IRQ_WIDTH-1:0] irq_set;
      logic [IRQ_WIDTH-1:0] irq_w1c;
      cond = fault_sync;
      new_code = FAULT_NONE;
      wr_fault = reg_write && (reg_addr == ADDR_ACTIVE_FAULT);
      clear_req = 1'b0;
      refused = 1'b0;
      irq_set = '0;
      irq_w1c = '0;
      st_next = st_reg;

      // undervoltage is not a fault while the drive is disabled
      cond[FAULT_UNDERVOLT_INDEX] = fault_sync[FAULT_UNDERVOLT_INDEX] && drive_enabled; // see R4
      // lowest index wins when several conditions rise together
      for (int i = FAULT_COUNT - 1; i >= 0; i--) begin
         if (cond[i]) begin
            new_code = FAULT_CODES[i]; // see R5 see R6 see R7 see R8 see R9 see R10
         end
      end

      // only zero is a legal write; anything else is refused
      if (wr_fault) begin
         if (reg_wdata == FAULT_CLEAR_VALUE) begin
            clear_req = 1'b1; // see R3
         end else begin
            refused = 1'b1;
         end
      end
      if (clear_pin_sync) begin
         clear_req = 1'b1; // see R3
      end

      // fault latch: upgrade, then clear, then a new fault
      if (fw_upgrade_sync) begin
         st_next.fault_code = FAULT_FW_UPGRADE_CODE; // see R11
         st_next.fault_active = 1'b1;
      end else if (clear_req) begin
         // a condition still present relatches on the next cycle
         st_next.fault_code = FAULT_NONE; // see R17
         st_next.fault_active = 1'b0;
         irq_set[IRQ_FAULT_CLEARED] = st_reg.fault_active;
      end else if (!st_reg.fault_active && (cond != '0)) begin
         st_next.fault_code = new_code; // see R1
         st_next.fault_active = 1'b1;
         irq_set[IRQ_FAULT_RAISED] = 1'b1;
      end
      // a latched fault holds, even after the condition goes away
      // see R4

      if (reg_write) begin
         unique case (reg_addr)
            ADDR_STATUS_SELECT: begin
               if (reg_wdata <= STATUS_SELECT_MAX) begin
                  st_next.status_sel = reg_wdata; // see R13
               end else begin
                  refused = 1'b1;
               end
            end
            ADDR_LOCKED_PARAM: begin
               if (drive_enabled) begin
                  refused = 1'b1; // see R14
               end else begin
                  st_next.locked = reg_wdata;
               end
            end
            ADDR_RESTART_PARAM: begin
               st_next.restart_staged = reg_wdata; // see R15
            end
            ADDR_VOLATILE_PARAM: begin
               st_next.volatile_val = reg_wdata;
            end
            ADDR_IRQ_STATUS: begin
               irq_w1c = reg_wdata[IRQ_WIDTH-1:0];
            end
            ADDR_IRQ_MASK: begin
               st_next.irq_mask = reg_wdata[IRQ_WIDTH-1:0];
            end
            ADDR_FW_REVISION, ADDR_RESTART_ACTIVE: begin
               refused = 1'b1; // see R18
            end
            default: begin
            end
         endcase
      end

      // power loss: volatile values drop, restart values take effect
      if (power_cycle) begin
         st_next.volatile_val = PARAM_RESET; // see R16
         st_next.restart_active = st_reg.restart_staged; // see R15
      end

      irq_set[IRQ_WRITE_REFUSED] = refused;
      // set beats a simultaneous write-one-to-clear
      st_next.irq_status = (st_reg.irq_status & ~irq_w1c) | irq_set;
      st_next.irq = (st_next.irq_status & st_next.irq_mask) != '0;

      st_next.rd_data = READ_IDLE;
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_FW_REVISION: st_next.rd_data = firmware_revision_word; // see R12
            ADDR_ACTIVE_FAULT: st_next.rd_data = st_reg.fault_code; // see R1 see R2
            ADDR_STATUS_SELECT: st_next.rd_data = st_reg.status_sel;
            ADDR_LOCKED_PARAM: st_next.rd_data = st_reg.locked;
            ADDR_RESTART_PARAM: st_next.rd_data = st_reg.restart_staged;
            ADDR_RESTART_ACTIVE: st_next.rd_data = st_reg.restart_active;
            ADDR_VOLATILE_PARAM: st_next.rd_data = st_reg.volatile_val;
            ADDR_IRQ_STATUS: st_next.rd_data = {{(16-IRQ_WIDTH){1'b0}}, st_reg.irq_status};
            ADDR_IRQ_MASK: st_next.rd_data = {{(16-IRQ_WIDTH){1'b0}}, st_reg.irq_mask};
            default: st_next.rd_data = READ_IDLE;
         endcase
      end

      st_next.fault_bcd = bcd_of_code; // see R2
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rd_data;
   assign irq = st_reg.irq;
   assign fault_active = st_reg.fault_active;
   assign active_fault_code = st_reg.fault_code;
   assign fault_bcd = st_reg.fault_bcd;
   assign status_item_select = st_reg.status_sel;
   assign locked_value = st_reg.locked;
   assign restart_value = st_reg.restart_active;
   assign volatile_value = st_reg.volatile_val;

   default clocking main_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence seq_zero_write;
      reg_write && (reg_addr == ADDR_ACTIVE_FAULT) && (reg_wdata == FAULT_CLEAR_VALUE);
   endsequence

   sequence seq_upgrade_idle;
      !fw_upgrade_sync;
   endsequence

   sequence seq_locked_write;
      reg_write && (reg_addr == ADDR_LOCKED_PARAM) && drive_enabled;
   endsequence

   a_fault_zero_idle: assert property ( // see R17
      !st_reg.fault_active |-> (st_reg.fault_code == FAULT_NONE))
      else $error("fault code nonzero with no fault latched");

   a_zero_write_clears: assert property ( // see R3
      (seq_zero_write and seq_upgrade_idle) |=> !st_reg.fault_active)
      else $error("zero write did not clear the fault");

   a_uv_needs_enable: assert property ( // see R4
      (!st_reg.fault_active ##1 (st_reg.fault_code == FAULT_UNDERVOLT_CODE))
      |-> $past(drive_enabled))
      else $error("undervoltage raised while drive disabled");

   a_uv_stays_latched: assert property ( // see R4
      ((st_reg.fault_code == FAULT_UNDERVOLT_CODE) && !clear_pin_sync && !fw_upgrade_sync
       && !(reg_write && (reg_addr == ADDR_ACTIVE_FAULT)))
      |=> (st_reg.fault_code == FAULT_UNDERVOLT_CODE))
      else $error("undervoltage fault dropped without clear");

   a_upgrade_code_shown: assert property ( // see R11
      fw_upgrade_sync |=> (st_reg.fault_code == FAULT_FW_UPGRADE_CODE) && st_reg.fault_active)
      else $error("upgrade code not shown");

   a_select_in_range: assert property ( // see R13
      st_reg.status_sel <= STATUS_SELECT_MAX)
      else $error("status selector out of range");

   a_locked_refuses: assert property ( // see R14
      seq_locked_write |=> $stable(st_reg.locked) ##1 st_reg.irq_status[IRQ_WRITE_REFUSED])
      else $error("locked parameter changed while enabled");

   a_restart_waits: assert property ( // see R15
      !$stable(st_reg.restart_active) |-> $past(power_cycle))
      else $error("restart parameter applied without power cycle");

   a_volatile_lost: assert property ( // see R16
      power_cycle |=> (st_reg.volatile_val == PARAM_RESET))
      else $error("volatile parameter survived power cycle");

   a_revision_read: assert property ( // see R12
      (reg_read && (reg_addr == ADDR_FW_REVISION)) |=> (reg_rdata == firmware_revision_word))
      else $error("revision word read wrong");

   a_fault_read: assert property ( // see R1
      (reg_read && (reg_addr == ADDR_ACTIVE_FAULT)) |=> (reg_rdata == $past(st_reg.fault_code)))
      else $error("fault register read wrong");

   a_bcd_low_digit: assert property ( // see R2
      ##1 (fault_bcd[3:0] == 4'($past(st_reg.fault_code) % 16'h000a)))
      else $error("panel bcd digit wrong");

   a_ro_write_ignored: assert property ( // see R18
      (reg_write && (reg_addr == ADDR_RESTART_ACTIVE) && !power_cycle)
      |=> $stable(st_reg.restart_active))
      else $error("read-only register changed by write");

   a_clear_pin_clears: assert property ( // see R3
      (clear_pin_sync && !fw_upgrade_sync) |=> !st_reg.fault_active)
      else $error("clear input did not clear the fault");

   a_nonzero_refused: assert property ( // see R3
      (st_reg.fault_active && reg_write && (reg_addr == ADDR_ACTIVE_FAULT)
       && (reg_wdata != FAULT_CLEAR_VALUE) && !clear_pin_sync && !fw_upgrade_sync)
      |=> $stable(st_reg.fault_code) && st_reg.irq_status[IRQ_WRITE_REFUSED])
      else $error("nonzero write changed the fault code");

   a_select_refused: assert property ( // see R13
      (reg_write && (reg_addr == ADDR_STATUS_SELECT) && (reg_wdata > STATUS_SELECT_MAX))
      |=> $stable(st_reg.status_sel))
      else $error("out of range selector value taken");

   // guards the priority order as well as the latch itself
   a_first_fault_code: assert property ( // see R1
      (!st_reg.fault_active && fault_sync[0] && !clear_pin_sync && !fw_upgrade_sync
       && !(reg_write && (reg_addr == ADDR_ACTIVE_FAULT)))
      |=> (st_reg.fault_code == FAULT_CODES[0]))
      else $error("highest priority fault code not latched");

   a_rdata_idle: assert property (
      !reg_read |=> (reg_rdata == READ_IDLE))
      else $error("read data not idle without a read");

endmodule // drive_fault_status_regs
`default_nettype wire

/* File: drive_fault_status_regs_tb.sv */
// self-checking testbench of the drive fault register bank
`timescale 1ns/1ps
`default_nettype none
module drive_fault_status_regs_tb;
   import drive_fault_pkg::*;
   localparam logic [15:0] FW_REV = 16'h0215; // arbitrary value
   localparam int CODES [23] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 13, 14, 15, 17, 18, 19,
      20, 23, 24, 25, 26, 48, 67};
   logic clk, reset_n, drive_enabled, power_cycle, fault_clear_input, fw_upgrade_pin;
   logic [22:0] fault_cond_pins;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, active_fault_code, fault_bcd, status_item_select;
   logic [15:0] locked_value, restart_value, volatile_value, v, exp;
   logic reg_write, reg_read, irq, fault_active;
   logic [31:0] seed = 32'hb1e07c68;
   int miscompares = 0;
   int checked = 0;

   always #2 clk = ~clk;

   fault_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   drive_fault_status_regs #(.firmware_revision_word(FW_REV)) DUT (.clk(clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .drive_enabled(drive_enabled),
      .power_cycle(power_cycle), .fault_cond_pins(fault_cond_pins),
      .fault_clear_input(fault_clear_input), .fw_upgrade_pin(fw_upgrade_pin), .irq(irq),
      .fault_active(fault_active), .active_fault_code(active_fault_code),
      .fault_bcd(fault_bcd), .status_item_select(status_item_select),
      .locked_value(locked_value), .restart_value(restart_value),
      .volatile_value(volatile_value));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] bcd(int n);
      return {4'(n / 1000), 4'((n / 100) % 10), 4'((n / 10) % 10), 4'(n % 10)};
   endfunction

   task automatic check(string name, logic [15:0] seen, logic [15:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
      end
   endtask

   task automatic rchk(string name, logic [7:0] a, logic [15:0] want);
      logic [15:0] d;
      host.rd(a, d);
      check(name, d, want);
   endtask

   // waits n edges, then steps past the edge so outputs are settled
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      drive_enabled = 1'b0;
      power_cycle = 1'b0;
      fault_clear_input = 1'b0;
      fw_upgrade_pin = 1'b0;
      fault_cond_pins = '0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rchk("fw_revision", ADDR_FW_REVISION, FW_REV);
      rchk("status_reset", ADDR_STATUS_SELECT, 16'h0000);
      rchk("fault_idle", ADDR_ACTIVE_FAULT, 16'h0000);
      host.wr(ADDR_FW_REVISION, 16'hffff);
      rchk("fw_after_write", ADDR_FW_REVISION, FW_REV);
      rchk("unmapped", 8'h20, READ_IDLE);
      // undervoltage is ignored while the drive is off
      @(posedge clk);
      fault_cond_pins <= 23'h000004;
      tick(6);
      check("uv_disabled", active_fault_code, 16'h0000);
      @(posedge clk);
      drive_enabled <= 1'b1;
      tick(6);
      check("uv_enabled", active_fault_code, 16'h0003);
      @(posedge clk);
      fault_cond_pins <= '0;
      tick(6);
      check("uv_latched", active_fault_code, 16'h0003);
      host.wr(ADDR_ACTIVE_FAULT, 16'h0001);
      #1;
      check("nonzero_write", active_fault_code, 16'h0003);
      @(posedge clk);
      fault_clear_input <= 1'b1;
      tick(6);
      check("clear_pin", {15'h0, fault_active}, 16'h0000);
      @(posedge clk);
      fault_clear_input <= 1'b0;
      tick(3);
      for (int i = 0; i < 23; i++) begin
         @(posedge clk);
         fault_cond_pins <= 23'(1) << i;
         tick(6);
         check("fault_code", active_fault_code, 16'(CODES[i]));
         check("fault_bcd", fault_bcd, bcd(CODES[i]));
         rchk("fault_reg", ADDR_ACTIVE_FAULT, 16'(CODES[i]));
         @(posedge clk);
         fault_cond_pins <= '0;
         tick(3);
         host.clear_fault();
         #1;
         check("fault_cleared", active_fault_code, 16'h0000);
      end
      // interrupt: status already set, unmask, clear, raise again, mask
      host.wr(ADDR_IRQ_MASK, 16'h0001);
      tick(2);
      check("irq_unmasked", {15'h0, irq}, 16'h0001);
      host.wr(ADDR_IRQ_STATUS, 16'h0007);
      tick(2);
      check("irq_cleared", {15'h0, irq}, 16'h0000);
      @(posedge clk);
      fault_cond_pins <= 23'h000001;
      tick(6);
      check("irq_raised", {15'h0, irq}, 16'h0001);
      host.wr(ADDR_IRQ_MASK, 16'h0000);
      tick(2);
      check("irq_masked", {15'h0, irq}, 16'h0000);
      @(posedge clk);
      fault_cond_pins <= '0;
      tick(3);
      host.clear_fault();
      // upgrade code stays latched after the pin falls
      @(posedge clk);
      fw_upgrade_pin <= 1'b1;
      tick(6);
      check("upgrade_code", active_fault_code, 16'h0063);
      @(posedge clk);
      fw_upgrade_pin <= 1'b0;
      tick(6);
      check("upgrade_held", active_fault_code, 16'h0063);
      host.clear_fault();
      #1;
      check("upgrade_cleared", active_fault_code, 16'h0000);
      exp = 16'h0000;
      for (int i = 0; i < 24; i++) begin
         v = (i == 0) ? 16'h0012 : (i == 1) ? 16'h0013 : 16'(xs() % 32);
         host.wr(ADDR_STATUS_SELECT, v);
         if (v <= 16'h0012) exp = v;
         rchk("status_select", ADDR_STATUS_SELECT, exp);
         check("status_port", status_item_select, exp);
      end
      v = 16'(xs());
      @(posedge clk);
      drive_enabled <= 1'b1;
      host.wr(ADDR_LOCKED_PARAM, v);
      #1;
      check("locked_refused", locked_value, PARAM_RESET);
      @(posedge clk);
      drive_enabled <= 1'b0;
      host.wr(ADDR_LOCKED_PARAM, v);
      #1;
      check("locked_taken", locked_value, v);
      host.wr(ADDR_RESTART_PARAM, v);
      host.wr(ADDR_VOLATILE_PARAM, ~v);
      #1;
      check("restart_pending", restart_value, PARAM_RESET);
      check("volatile_set", volatile_value, ~v);
      @(posedge clk);
      power_cycle <= 1'b1;
      @(posedge clk);
      power_cycle <= 1'b0;
      #1;
      check("restart_applied", restart_value, v);
      check("volatile_lost", volatile_value, PARAM_RESET);
      host.wr(ADDR_RESTART_ACTIVE, ~v);
      rchk("restart_reg", ADDR_RESTART_ACTIVE, v);
      tick(1);
      check("rdata_idle", reg_rdata, READ_IDLE);
      rchk("locked_reg", ADDR_LOCKED_PARAM, v);
      rchk("restart_staged", ADDR_RESTART_PARAM, v);
      rchk("volatile_reg", ADDR_VOLATILE_PARAM, PARAM_RESET);
      rchk("irq_mask_reg", ADDR_IRQ_MASK, 16'h0000);
      rchk("irq_status_reg", ADDR_IRQ_STATUS, 16'h0007);
      host.wr(ADDR_IRQ_STATUS, 16'h0002);
      rchk("irq_status_w1c", ADDR_IRQ_STATUS, 16'h0005);
      report_and_stop();
   end
endmodule // drive_fault_status_regs_tb
`default_nettype wire

/* File: fault_host_model.sv */
// host model driving the plain register port of the fault bank
`timescale 1ns/1ps
`default_nettype none
module fault_host_model
   import drive_fault_pkg::*;
(
   input wire logic clk,                                          // system clock
   output var logic [drive_fault_pkg::ADDR_WIDTH-1:0] reg_addr,   // register address
   output var logic [drive_fault_pkg::DATA_WIDTH-1:0] reg_wdata,  // write data
   output var logic reg_write,                                    // write strobe
   output var logic reg_read,                                     // read strobe
   input wire logic [drive_fault_pkg::DATA_WIDTH-1:0] reg_rdata   // read data
);
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d; // stale data must never look like a fresh write
   endtask

   task automatic rd(input logic [ADDR_WIDTH-1:0] a, output logic [DATA_WIDTH-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // only zero is a legal value for the fault register
   task automatic clear_fault();
      wr(ADDR_ACTIVE_FAULT, FAULT_CLEAR_VALUE);
   endtask
endmodule // fault_host_model
`default_nettype wire

/* File: pin_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,                  // system clock
   input wire logic reset_n,              // async reset, active low
   input wire logic [WIDTH-1:0] pin_in,   // raw pins
   output logic [WIDTH-1:0] sync_out      // synchronised levels
);
   logic [WIDTH-1:0] meta_reg;

   // meta_reg is read by sync_out only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_out <= meta_reg;
      end
   end
endmodule // pin_sync
`default_nettype wire
